// ==== core/cioc_pkg.sv ====
/*
 * Package of the configurable input counter: register map, field layouts,
 * modes, edge selections, reset values and the bus carrier struct.
 * Assumes a single 100 MHz system clock and a plain strobe register port.
 */
package cioc_pkg;

	localparam int NUM_CH  = 32;                   // Configurable input channels
	localparam int NUM_BLK = 4;                    // Counter blocks, eight pins each
	localparam int BLK_CH  = 8;                    // Channels per block and per bank
	localparam int CNT_W   = 16;                   // Counter and match width
	localparam int ADDR_W  = 8;                    // Register address width
	localparam int DATA_W  = 32;                   // Register data width
	localparam int CH_W    = 5;                    // Channel number width
	localparam int FN_W    = 2;                    // Per-channel function field width

	localparam logic [CNT_W-1:0] CNT_MAX   = 16'hffff; // Match and limit maximum
	localparam logic [CNT_W-1:0] LIMIT_RST = 16'hffff; // Limit after reset

	// Global registers
	localparam logic [ADDR_W-1:0] R_LEVEL     = 8'h00; // All 32 pin levels
	localparam logic [ADDR_W-1:0] R_BANK0     = 8'h04; // Bank n at R_BANK0 + n*R_STEP
	localparam logic [ADDR_W-1:0] R_STEP      = 8'h04; // Word step
	localparam logic [ADDR_W-1:0] R_FUNC_LO   = 8'h14; // Functions of channels 0-15
	localparam logic [ADDR_W-1:0] R_FUNC_HI   = 8'h18; // Functions of channels 16-31
	localparam logic [ADDR_W-1:0] R_IRQSEL_LO = 8'h1c; // Interrupt edges, channels 0-15
	localparam logic [ADDR_W-1:0] R_IRQSEL_HI = 8'h20; // Interrupt edges, channels 16-31
	localparam logic [ADDR_W-1:0] R_STAT      = 8'h24; // Sticky interrupt status
	localparam logic [ADDR_W-1:0] R_CLR       = 8'h28; // Write one to clear status
	localparam logic [ADDR_W-1:0] R_EN        = 8'h2c; // Interrupt enable

	// Per-block registers at BLK_BASE + b*BLK_STRIDE + offset
	localparam logic [ADDR_W-1:0] BLK_BASE    = 8'h40;
	localparam logic [ADDR_W-1:0] BLK_STRIDE  = 8'h20;
	localparam logic [ADDR_W-1:0] BR_CTRL     = 8'h00; // Mode and channel selection
	localparam logic [ADDR_W-1:0] BR_OPT      = 8'h04; // Option word
	localparam logic [ADDR_W-1:0] BR_LIMIT    = 8'h08; // Pending limit
	localparam logic [ADDR_W-1:0] BR_COUNT    = 8'h0c; // Count; a write resets it
	localparam logic [ADDR_W-1:0] BR_MATCH0   = 8'h10; // Match register 0
	localparam logic [ADDR_W-1:0] BR_MATCH1   = 8'h14; // Match register 1
	localparam logic [ADDR_W-1:0] BR_CONFLICT = 8'h18; // Pin conflict bitmap

	// Edge selection for counting and synch
	typedef enum logic [1:0] {
		edge_sel_none    = 2'h0,
		edge_sel_rising  = 2'h1,
		edge_sel_falling = 2'h2,
		edge_sel_any     = 2'h3
	} cioc_edge_t;

	// Edge selection for interrupt channels
	typedef enum logic [1:0] {
		irq_off        = 2'h0,
		irq_on_rising  = 2'h1,
		irq_on_falling = 2'h2,
		irq_on_any     = 2'h3
	} cioc_irq_t;

	// Channel function
	typedef enum logic [FN_W-1:0] {
		fn_digital_in = 2'h0,
		fn_irq        = 2'h1,
		fn_quad       = 2'h2,
		fn_count      = 2'h3
	} cioc_func_t;

	// Block counter mode
	typedef enum logic [2:0] {
		mode_off           = 3'h0,
		mode_up_only       = 3'h1,
		mode_up_down       = 3'h2,
		mode_stop_on_match = 3'h3,
		mode_quad          = 3'h4
	} cioc_mode_t;

	// Block control word
	typedef struct packed {
		logic [2:0]     rsv;       // Stored and read back as written
		cioc_edge_t     sync_edge; // Synch edge, none disables
		logic [CH_W-1:0] sync_ch;  // Synch source channel
		logic           idx_pol;   // Index active level
		logic           idx_en;    // Index in use
		logic [CH_W-1:0] idx_ch;   // Index channel
		logic [CH_W-1:0] b_ch;     // Quadrature input
		cioc_edge_t     up_edge;   // Up count edge
		logic [CH_W-1:0] up_ch;    // Up input, also in-phase input
		cioc_mode_t     mode;      // Counter mode
	} cioc_ctrl_t;

	// Option word in up/down mode
	typedef struct packed {
		logic [5:0]      rsv_hi;  // Unused
		cioc_edge_t      dn_edge; // Down count edge
		logic [2:0]      rsv_lo;  // Unused
		logic [CH_W-1:0] dn_ch;   // Down input channel
	} cioc_opt_t;

	// One counter block
	typedef struct packed {
		cioc_ctrl_t       ctrl;
		cioc_opt_t        opt;
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] limit_act;  // Limit in force
		logic [CNT_W-1:0] limit_pend; // Limit taking effect later
		logic [CNT_W-1:0] match0;
		logic [CNT_W-1:0] match1;
		logic             stopped;    // Stop-on-match has hit
	} cioc_blk_t;

	// Register port request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} cioc_req_t;

endpackage : cioc_pkg

// ==== core/cioc_top.sv ====
/*
 * Configurable input counter: 32 synchronised pins, level and bank reads,
 * edge interrupts and four 16-bit counter blocks (up, up/down, stop on
 * match, quadrature). Assumes one clock, pins asynchronous to it, and a
 * register master that keeps to single-cycle strobes.
 */
// What this block does
// RULE1: Thirty-two channels usable as digital inputs
// RULE2: Channel read gives pin level, 0 or 1
// RULE3: Bank byte, lowest channel in D0
// RULE4: Four banks cover all 32 channels
// RULE5: Interrupt channels fire on selected edge
// RULE6: Quadrature decode with optional polarity-selectable index
// RULE7: Synch still resets quadrature count
// RULE8: Counter steps one per selected edge
// RULE9: Count readable; software reset clears it
// RULE10: Up mode counts on selected edge
// RULE11: Up/down uses two distinct pins
// RULE12: Down channel from option low five bits
// RULE13: Stop-on-match halts counting at match
// RULE14: Stop mode loads match, others maximum
// RULE15: Conflict bitmap names misconfigured block pins
// RULE16: New limit applies at overflow or reset
// RULE17: Own synch edge detector per block
// RULE18: Counter and matches sixteen bits, reset zero
// RULE19: Pins synchronised; one pulse per edge
`timescale 1ns/1ps
module cioc_top (
	input  wire logic                    clock_i,   // System clock
	input  wire logic                    rst_n_i,   // Asynchronous reset, active low
	input  wire logic [31:0]             pin_i,     // Pins cfg_io_pin 0-31
	input  wire cioc_pkg::cioc_req_t     req_i,     // Register request
	output logic [cioc_pkg::DATA_W-1:0]  rdata_o,   // Read data, cycle after read
	output logic                         irq_o      // Level interrupt
);
	import cioc_pkg::*;

	// Whole module state
	typedef struct packed {
		logic [NUM_CH-1:0]      s1;      // First synchroniser stage
		logic [NUM_CH-1:0]      s2;      // Second stage
		logic [NUM_CH-1:0]      s3;      // Third stage
		logic [NUM_CH-1:0]      lvl;     // Accepted pin level
		logic [2*NUM_CH-1:0]    func;    // Channel functions
		logic [2*NUM_CH-1:0]    irqsel;  // Channel interrupt edges
		logic [NUM_CH-1:0]      stat;    // Sticky interrupt status
		logic [NUM_CH-1:0]      en;      // Interrupt enable
		logic [DATA_W-1:0]      rdata;   // Registered read data
		cioc_blk_t [NUM_BLK-1:0] blk;    // Counter blocks
	} cioc_state_t;

	cioc_state_t st;                       // Registered state
	cioc_state_t next_st;                  // Next state
	logic [NUM_CH-1:0]  rise;              // One-cycle rising edge events
	logic [NUM_CH-1:0]  fall;              // One-cycle falling edge events
	logic [NUM_BLK-1:0] up_ev;             // Up count events
	logic [NUM_BLK-1:0] dn_ev;             // Down count events
	logic [NUM_BLK-1:0] sync_ev;           // Synch events
	logic [NUM_BLK-1:0] idx_ev;            // Index events
	logic [NUM_BLK-1:0] q_up;              // Quadrature forward step
	logic [NUM_BLK-1:0] q_dn;              // Quadrature reverse step
	logic [BLK_CH-1:0]  conflict [NUM_BLK]; // Conflict bitmaps

	// Edge match against a selection
	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		edge_hit = (sel[0] & r) | (sel[1] & f);
	endfunction : edge_hit

	// Address of a per-block register
	function automatic logic [ADDR_W-1:0] blk_addr(input int b, input logic [ADDR_W-1:0] off);
		blk_addr = BLK_BASE + ADDR_W'(b) * BLK_STRIDE + off;
	endfunction : blk_addr

	// Function field of one channel
	function automatic cioc_func_t func_of(input logic [2*NUM_CH-1:0] v, input int ch);
		func_of = cioc_func_t'(v[FN_W*ch +: FN_W]);
	endfunction : func_of

	// Edge events once stages two and three agree
	assign rise = ~(st.s2 ^ st.s3) & st.s3 & ~st.lvl; // RULE19
	assign fall = ~(st.s2 ^ st.s3) & ~st.s3 & st.lvl; // RULE19

	// Per-block event decode
	for (genvar b = 0; b < NUM_BLK; b++) begin : g_blk
		cioc_ctrl_t      c;                // Block control
		logic            a_ev;             // In-phase edge
		logic            b_ev;             // Quadrature edge
		logic            new_a;            // In-phase level after edge
		logic [CH_W-1:0] dch;              // Down channel
		assign c     = st.blk[b].ctrl;
		assign dch   = st.blk[b].opt.dn_ch; // RULE12
		assign up_ev[b] = edge_hit(c.up_edge, rise[c.up_ch], fall[c.up_ch]); // RULE8
		// Down pin must differ from up pin
		assign dn_ev[b] = (dch != c.up_ch) &&
			edge_hit(st.blk[b].opt.dn_edge, rise[dch], fall[dch]); // RULE11
		assign sync_ev[b] = edge_hit(c.sync_edge, rise[c.sync_ch], fall[c.sync_ch]); // RULE17
		assign idx_ev[b]  = c.idx_en &&
			(c.idx_pol ? rise[c.idx_ch] : fall[c.idx_ch]); // RULE6
		// Single-step quadrature: direction from new A against old B
		assign a_ev  = rise[c.up_ch] | fall[c.up_ch];
		assign b_ev  = rise[c.b_ch] | fall[c.b_ch];
		assign new_a = a_ev ? st.s3[c.up_ch] : st.lvl[c.up_ch];
		assign q_up[b] = (a_ev ^ b_ev) & (new_a ^ st.lvl[c.b_ch]);  // RULE6
		assign q_dn[b] = (a_ev ^ b_ev) & ~(new_a ^ st.lvl[c.b_ch]); // RULE6
		// Block pins used by the mode but set to another function
		for (genvar j = 0; j < BLK_CH; j++) begin : g_pin
			localparam int CH = b * BLK_CH + j;
			logic use_cnt; // Pin needed as counter input
			logic use_q;   // Pin needed as quadrature input
			assign use_cnt = (c.mode inside {mode_up_only, mode_up_down, mode_stop_on_match}
				&& c.up_ch == CH_W'(CH)) || (c.mode == mode_up_down && dch == CH_W'(CH));
			assign use_q = c.mode == mode_quad && (c.up_ch == CH_W'(CH) ||
				c.b_ch == CH_W'(CH) || (c.idx_en && c.idx_ch == CH_W'(CH)));
			assign conflict[b][j] = (use_cnt && func_of(st.func, CH) != fn_count) ||
				(use_q && func_of(st.func, CH) != fn_quad); // RULE15
		end
	end

	// Next state: synchronisers, interrupts, counters, register access
	always_comb begin
		logic [NUM_CH-1:0] clr;   // Status bits cleared this cycle
		logic              inc;   // Count up this cycle
		logic              dec;   // Count down this cycle
		logic              load;  // Stop-mode match load
		cioc_blk_t         bs;    // Working block copy
		clr  = '0;
		inc  = 1'b0;
		dec  = 1'b0;
		load = 1'b0;
		bs   = '0;
		next_st = st;
		// Three-stage synchroniser, level accepted on agreement
		next_st.s1 = pin_i;    // RULE1
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < NUM_CH; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.lvl[i] = st.s3[i]; // RULE19
			end
		end
		// Global register writes
		if (req_i.wr) begin
			unique case (req_i.addr)
				R_FUNC_LO:   next_st.func[DATA_W-1:0]       = req_i.wdata;
				R_FUNC_HI:   next_st.func[2*DATA_W-1:DATA_W] = req_i.wdata;
				R_IRQSEL_LO: next_st.irqsel[DATA_W-1:0]       = req_i.wdata;
				R_IRQSEL_HI: next_st.irqsel[2*DATA_W-1:DATA_W] = req_i.wdata;
				R_CLR:       clr = req_i.wdata;
				R_EN:        next_st.en = req_i.wdata;
				default:     ;
			endcase
		end
		// Sticky status: a new event wins over a clear
		for (int i = 0; i < NUM_CH; i++) begin
			next_st.stat[i] = (st.stat[i] & ~clr[i]) |
				(func_of(st.func, i) == fn_irq &&
				 edge_hit(st.irqsel[FN_W*i +: FN_W], rise[i], fall[i])); // RULE5
		end
		// Counter blocks
		for (int b = 0; b < NUM_BLK; b++) begin
			bs  = st.blk[b];
			inc = 1'b0;
			dec = 1'b0;
			unique case (bs.ctrl.mode)
				mode_up_only:       inc = up_ev[b];           // RULE10
				mode_up_down: begin
					inc = up_ev[b];                              // RULE11
					dec = dn_ev[b];                              // RULE11
				end
				mode_stop_on_match: inc = up_ev[b] & ~bs.stopped; // RULE13
				mode_quad: begin
					inc = q_up[b];
					dec = q_dn[b];
				end
				default: ;
			endcase
			if (req_i.wr && req_i.addr == blk_addr(b, BR_COUNT)) begin
				// Forced reset clears count and matches
				bs.count     = '0;           // RULE9
				bs.match0    = '0;           // RULE18
				bs.match1    = '0;           // RULE18
				bs.stopped   = 1'b0;
				bs.limit_act = bs.limit_pend; // RULE16
			end else if (sync_ev[b] || (bs.ctrl.mode == mode_quad && idx_ev[b])) begin
				// Synch restarts the count in every mode, index in quadrature mode only
				bs.count     = '0;           // RULE7
				bs.stopped   = 1'b0;
				bs.limit_act = bs.limit_pend; // RULE16
			end else if (inc && !dec) begin
				if (bs.count == bs.limit_act) begin
					bs.count     = '0;
					bs.limit_act = bs.limit_pend; // RULE16
				end else begin
					bs.count = bs.count + 1'b1;   // RULE8
				end
				// Match event stops further counting
				if (bs.ctrl.mode == mode_stop_on_match &&
					(bs.count == bs.match0 || bs.count == bs.match1)) begin
					bs.stopped = 1'b1;            // RULE13
				end
			end else if (dec && !inc) begin
				if (bs.count == '0) begin
					bs.count     = bs.limit_act;
					bs.limit_act = bs.limit_pend; // RULE16
				end else begin
					bs.count = bs.count - 1'b1;   // RULE8
				end
			end
			// Block register writes
			load = 1'b0;
			if (req_i.wr && req_i.addr == blk_addr(b, BR_CTRL)) begin
				bs.ctrl    = cioc_ctrl_t'(req_i.wdata);
				bs.stopped = 1'b0;
				load       = bs.ctrl.mode == mode_stop_on_match;
			end
			if (req_i.wr && req_i.addr == blk_addr(b, BR_OPT)) begin
				bs.opt = cioc_opt_t'(req_i.wdata[CNT_W-1:0]); // RULE12
				load   = bs.ctrl.mode == mode_stop_on_match;
			end
			if (load) begin
				bs.match0 = CNT_W'(bs.opt);       // RULE14
				bs.match1 = CNT_MAX;              // RULE14
			end
			if (req_i.wr && req_i.addr == blk_addr(b, BR_LIMIT)) begin
				bs.limit_pend = req_i.wdata[CNT_W-1:0]; // RULE16
			end
			next_st.blk[b] = bs;
		end
		// Read data stand for one cycle only
		next_st.rdata = '0;
		if (req_i.rd) begin
			unique case (req_i.addr)
				R_LEVEL:     next_st.rdata = st.lvl;                   // RULE2
				R_FUNC_LO:   next_st.rdata = st.func[DATA_W-1:0];
				R_FUNC_HI:   next_st.rdata = st.func[2*DATA_W-1:DATA_W];
				R_IRQSEL_LO: next_st.rdata = st.irqsel[DATA_W-1:0];
				R_IRQSEL_HI: next_st.rdata = st.irqsel[2*DATA_W-1:DATA_W];
				R_STAT:      next_st.rdata = st.stat;
				R_EN:        next_st.rdata = st.en;
				default:     ;
			endcase
			for (int n = 0; n < NUM_BLK; n++) begin
				if (req_i.addr == R_BANK0 + ADDR_W'(n) * R_STEP) begin
					next_st.rdata = DATA_W'(st.lvl[n*BLK_CH +: BLK_CH]); // RULE3 RULE4
				end
				if (req_i.addr == blk_addr(n, BR_CTRL)) begin
					next_st.rdata = st.blk[n].ctrl;
				end
				if (req_i.addr == blk_addr(n, BR_OPT)) begin
					next_st.rdata = DATA_W'(st.blk[n].opt);
				end
				if (req_i.addr == blk_addr(n, BR_LIMIT)) begin
					next_st.rdata = DATA_W'(st.blk[n].limit_pend);
				end
				if (req_i.addr == blk_addr(n, BR_COUNT)) begin
					next_st.rdata = DATA_W'(st.blk[n].count); // RULE9
				end
				if (req_i.addr == blk_addr(n, BR_MATCH0)) begin
					next_st.rdata = DATA_W'(st.blk[n].match0);
				end
				if (req_i.addr == blk_addr(n, BR_MATCH1)) begin
					next_st.rdata = DATA_W'(st.blk[n].match1);
				end
				if (req_i.addr == blk_addr(n, BR_CONFLICT)) begin
					next_st.rdata = DATA_W'(conflict[n]); // RULE15
				end
			end
		end
	end

	// State register
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
			for (int b = 0; b < NUM_BLK; b++) begin
				st.blk[b].limit_act  <= LIMIT_RST;
				st.blk[b].limit_pend <= LIMIT_RST;
			end
		end else begin
			st <= next_st;
		end
	end

	assign rdata_o = st.rdata;
	assign irq_o   = |(st.stat & st.en);

	// Each rising edge gives a single-cycle rise event
	property p_edge_once;
		@(posedge clock_i) disable iff (!rst_n_i)
		(rise != '0) |=> ((rise & $past(rise)) == '0);
	endproperty
	a_edge_once: assert property (p_edge_once) else $error("edge event longer than one cycle"); // RULE19

	// Level read returns the accepted pin levels
	property p_level_read;
		@(posedge clock_i) disable iff (!rst_n_i)
		(req_i.rd && req_i.addr == R_LEVEL) |=> (rdata_o == $past(st.lvl));
	endproperty
	a_level_read: assert property (p_level_read) else $error("level read mismatch"); // RULE2

	// Bank 3 read places channel 24 in D0
	property p_bank_read;
		@(posedge clock_i) disable iff (!rst_n_i)
		(req_i.rd && req_i.addr == R_BANK0 + ADDR_W'(NUM_BLK - 1) * R_STEP) |=>
			(rdata_o == DATA_W'($past(st.lvl[NUM_CH-1 -: BLK_CH])));
	endproperty
	a_bank_read: assert property (p_bank_read) else $error("bank read mismatch"); // RULE3

	// Rising edge on an interrupt channel 0 set for rising sets status
	property p_irq_set;
		@(posedge clock_i) disable iff (!rst_n_i)
		(rise[0] && st.func[FN_W-1:0] == fn_irq && st.irqsel[FN_W-1:0] == irq_on_rising)
			|=> (st.stat[0] && (irq_o || !st.en[0]));
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("interrupt not raised"); // RULE5

	// Software reset clears block 0 count and matches
	property p_soft_reset;
		@(posedge clock_i) disable iff (!rst_n_i)
		(req_i.wr && req_i.addr == BLK_BASE + BR_COUNT) |=>
			(st.blk[0].count == '0 && st.blk[0].match0 == '0 && st.blk[0].match1 == '0);
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("count not reset"); // RULE9

	// Stopped counter holds unless reset or reconfigured
	property p_stop_hold;
		@(posedge clock_i) disable iff (!rst_n_i)
		(st.blk[0].stopped && st.blk[0].ctrl.mode == mode_stop_on_match && !sync_ev[0]
			&& !req_i.wr) |=> $stable(st.blk[0].count);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("count moved after match"); // RULE13

	// Option write in stop mode loads match registers
	property p_match_load;
		@(posedge clock_i) disable iff (!rst_n_i)
		(req_i.wr && req_i.addr == BLK_BASE + BR_OPT &&
			st.blk[0].ctrl.mode == mode_stop_on_match) |=>
			(st.blk[0].match0 == $past(req_i.wdata[CNT_W-1:0]) && st.blk[0].match1 == CNT_MAX);
	endproperty
	a_match_load: assert property (p_match_load) else $error("match registers not loaded"); // RULE14

	// Up mode steps by exactly one on an up event
	property p_up_step;
		@(posedge clock_i) disable iff (!rst_n_i)
		(st.blk[0].ctrl.mode == mode_up_only && up_ev[0] && !sync_ev[0] && !req_i.wr &&
			st.blk[0].count != st.blk[0].limit_act) |=>
			(st.blk[0].count == $past(st.blk[0].count) + 16'h0001);
	endproperty
	a_up_step: assert property (p_up_step) else $error("up count step wrong"); // RULE10

	// A limit write leaves the active limit alone until overflow or reset
	property p_limit_defer;
		@(posedge clock_i) disable iff (!rst_n_i)
		(req_i.wr && req_i.addr == BLK_BASE + BR_LIMIT && !up_ev[0] && !dn_ev[0] &&
			!q_up[0] && !q_dn[0] && !sync_ev[0] && !idx_ev[0]) |=> $stable(st.blk[0].limit_act);
	endproperty
	a_limit_defer: assert property (p_limit_defer) else $error("limit applied early"); // RULE16

endmodule : cioc_top

// ==== verification/cioc_sig_model.sv ====
/*
 * Signal source model: drives the 32 pins the way external switches and
 * encoders would. Assumes the bench calls its tasks and shares the clock.
 */
`timescale 1ns/1ps
module cioc_sig_model (
	input  wire logic        clock_i, // System clock, pins move just after its edge
	output logic      [31:0] pin_o    // Pin levels
);
	// Pins start low so the synchroniser sees a known level from the start
	initial begin
		pin_o = 32'h0;
	end

	// Move the masked pins to the given levels, then hold past the synchroniser delay
	task automatic drive(input logic [31:0] mask, input logic [31:0] val);
		@(posedge clock_i);
		pin_o <= (pin_o & ~mask) | (val & mask);
		repeat (6) @(posedge clock_i);
	endtask : drive

	// One high pulse on a channel: a rising and then a falling edge
	task automatic pulse(input int ch);
		drive(32'h1 << ch, 32'hffffffff);
		drive(32'h1 << ch, 32'h0);
	endtask : pulse
endmodule : cioc_sig_model

// ==== verification/test_configurable_io_counter.sv ====
/*
 * Testbench of the configurable input counter: pin levels, banks,
 * interrupts, counter modes and the conflict bitmap.
 * Assumes cioc_pkg, cioc_top and the pin signal model.
 */
`timescale 1ns/1ps
module test_configurable_io_counter;
	import cioc_pkg::*;

	logic              clock_i;    // System clock
	logic              rst_n_i;    // Reset, active low
	logic [31:0]       pin_w;      // Pins from the signal model
	cioc_req_t         req;        // Register request
	logic [DATA_W-1:0] rdata;      // Read data
	logic              irq;        // Interrupt level
	int                num_errors; // Mismatches seen
	int                checked;    // Comparisons made

	// Device and its pin source
	cioc_top dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .pin_i(pin_w),
		.req_i(req), .rdata_o(rdata), .irq_o(irq));
	cioc_sig_model sig_u (.clock_i(clock_i), .pin_o(pin_w));

	// 100 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	// Compare one value and count it
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock_i);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clock_i);
		req.wr <= 1'b0;
	endtask : wr

	// One-cycle read strobe; data stand only in the following cycle
	task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock_i);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clock_i);
		req.rd <= 1'b0;
		#1 chk(what, exp, rdata);
	endtask : rc

	// Address of a register inside counter block b
	function automatic logic [7:0] ba(input int b, input logic [7:0] off);
		return BLK_BASE + 8'(b) * BLK_STRIDE + off;
	endfunction : ba

	// Full level word and every bank byte
	task automatic t_levels();
		sig_u.drive(32'hffffffff, 32'ha5c31e78);
		rc("level", R_LEVEL, 32'ha5c31e78);
		for (int n = 0; n < NUM_BLK; n++) begin
			rc("bank", R_BANK0 + 8'(n) * R_STEP, {24'h0, 8'(32'ha5c31e78 >> (8 * n))});
		end
		sig_u.drive(32'hffffffff, 32'h0);
	endtask : t_levels

	// Channel 0 rising, 1 falling, 2 any edge; then masking and clearing
	task automatic t_irq();
		wr(R_IRQSEL_LO, 32'h00000039);
		wr(R_EN, 32'h00000007);
		sig_u.drive(32'h7, 32'h7);
		rc("status rise", R_STAT, 32'h5);
		chk("irq high", 32'h1, {31'h0, irq});
		wr(R_CLR, 32'h7);
		sig_u.drive(32'h7, 32'h0);
		rc("status fall", R_STAT, 32'h6);
		wr(R_EN, 32'h0);
		#1 chk("irq masked", 32'h0, {31'h0, irq});
		wr(R_CLR, 32'h7);
		rc("status clear", R_STAT, 32'h0);
	endtask : t_irq

	// Up count on either edge of channel 3, then a forced reset
	task automatic t_up();
		wr(ba(0, BR_CTRL), 32'h00000319);
		repeat (2) sig_u.pulse(3);
		rc("up count", ba(0, BR_COUNT), 32'h4);
		wr(ba(0, BR_COUNT), 32'h0);
		rc("reset count", ba(0, BR_COUNT), 32'h0);
		// A new limit waits for the next reset, then wraps the count at 1
		wr(ba(0, BR_LIMIT), 32'h1);
		sig_u.pulse(3);
		rc("limit pending", ba(0, BR_COUNT), 32'h2);
		wr(ba(0, BR_COUNT), 32'h0);
		sig_u.pulse(3);
		rc("limit wrap", ba(0, BR_COUNT), 32'h0);
		wr(ba(0, BR_LIMIT), {16'h0, LIMIT_RST});
		wr(ba(0, BR_COUNT), 32'h0);
	endtask : t_up

	// Up on channel 8 rising, down on channel 9 rising
	task automatic t_updown();
		wr(ba(1, BR_CTRL), 32'h00000142);
		wr(ba(1, BR_OPT), 32'h00000109);
		repeat (3) sig_u.pulse(8);
		sig_u.pulse(9);
		rc("updown count", ba(1, BR_COUNT), 32'h2);
	endtask : t_updown

	// Stop at 2 on channel 3 rising edges, block 0 reused
	task automatic t_stop();
		wr(ba(0, BR_CTRL), 32'h0000011b);
		wr(ba(0, BR_OPT), 32'h00000002);
		rc("match0", ba(0, BR_MATCH0), 32'h2);
		rc("match1", ba(0, BR_MATCH1), {16'h0, CNT_MAX});
		repeat (4) sig_u.pulse(3);
		rc("stop count", ba(0, BR_COUNT), 32'h2);
	endtask : t_stop

	// Quadrature on block 2: A 16, B 17, index 18 rising; then synch on 19 rising
	task automatic t_quad();
		wr(ba(2, BR_CTRL), 32'h00394484);
		sig_u.drive(32'h10000, 32'h10000);
		sig_u.drive(32'h20000, 32'h20000);
		sig_u.drive(32'h10000, 32'h0);
		sig_u.drive(32'h20000, 32'h0);
		rc("quad forward", ba(2, BR_COUNT), 32'h4);
		sig_u.drive(32'h20000, 32'h20000);
		rc("quad reverse", ba(2, BR_COUNT), 32'h3);
		sig_u.pulse(18);
		rc("quad index", ba(2, BR_COUNT), 32'h0);
		wr(ba(2, BR_CTRL), 32'h0cf94484);
		sig_u.drive(32'h20000, 32'h0);
		rc("quad step", ba(2, BR_COUNT), 32'h1);
		sig_u.pulse(19);
		rc("synch reset", ba(2, BR_COUNT), 32'h0);
	endtask : t_quad

	// Block 3 counts on channel 24 left as plain input; an unmapped read
	task automatic t_conflict();
		wr(ba(3, BR_CTRL), 32'h000001c1);
		rc("conflict", ba(3, BR_CONFLICT), 32'h1);
		rc("unmapped", 8'h3c, 32'h0);
	endtask : t_conflict

	// Verdict and end of run
	task automatic summarize();
		if (num_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize

	// Hang guard
	initial begin
		repeat (20000) @(posedge clock_i);
		num_errors++;
		summarize();
	end

	// Main sequence
	initial begin
		rst_n_i = 1'b0;
		req = '0;
		num_errors = 0;
		checked = 0;
		repeat (2) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		wr(R_FUNC_LO, 32'h000f00d5);
		wr(R_FUNC_HI, 32'h0000002a);
		t_levels();
		t_irq();
		t_up();
		t_updown();
		t_stop();
		t_quad();
		t_conflict();
		summarize();
	end
endmodule : test_configurable_io_counter
